// File: rtl/spwc_pkg.sv
/*
 * Package for the system power and watchdog control block: sleep states,
 * power control requests, watchdog actions, timing constants and register map.
 * Assumes a 125 MHz management clock.
 */
package spwc_pkg;
	localparam int CLK_HZ = 125_000_000;
	// Power LED blink rate and half period (50% duty)
	localparam int BLINK_HZ = 1;
	localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
	// Quiet period after which the self-reset count clears
	localparam longint QUIET_MIN = 30;
	localparam longint QUIET_CYC = QUIET_MIN * 60 * CLK_HZ;
	localparam int SELF_RESET_MAX = 3;

	// Register offsets (byte addresses)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WDT_LOAD = 8'h08;
	localparam logic [7:0] REG_WDT_COUNT = 8'h0C;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_EVENT = 8'h14;

	// Control register fields
	localparam int CTRL_RETAIN_BIT = 0;
	localparam int CTRL_WDT_EN_BIT = 1;
	localparam int CTRL_WDT_LOG_BIT = 2;
	localparam int CTRL_WDT_USE_LSB = 4;
	localparam int CTRL_WDT_ACT_LSB = 8;
	localparam int CTRL_WORKSTATION_BIT = 12;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Command register codes
	localparam logic [1:0] CMD_ON = 2'h1;
	localparam logic [1:0] CMD_OFF = 2'h2;
	localparam logic [1:0] CMD_CYCLE = 2'h3;

	// Event register bits (write one to clear)
	localparam int EV_WDT_EXPIRED_BIT = 0;
	localparam int EV_BOOT_TIMEOUT_BIT = 1;
	localparam int EV_SELF_RESET_BIT = 2;

	// Host watchdog timer use codes
	localparam logic [2:0] WDT_USE_BOOT_PROGRESS = 3'h1;

	// Host watchdog timeout actions
	localparam logic [1:0] WDT_ACT_NONE = 2'h0;
	localparam logic [1:0] WDT_ACT_HARD_RESET = 2'h1;
	localparam logic [1:0] WDT_ACT_OFF = 2'h2;
	localparam logic [1:0] WDT_ACT_CYCLE = 2'h3;

	localparam int CYCLE_OFF_CYC = 125;
	localparam int SYS_RESET_CYC = 16;

	typedef enum logic [1:0] {
		SPWC_S0 = 2'b00,
		SPWC_S1 = 2'b01,
		SPWC_S3 = 2'b10,
		SPWC_S5 = 2'b11
	} spwc_sleep_t;

	typedef enum logic [1:0] {
		SPWC_PWR_OFF = 2'b00,
		SPWC_PWR_ON = 2'b01,
		SPWC_PWR_CYCLE = 2'b10
	} spwc_pwr_t;
endpackage

// File: rtl/spwc_top.sv
/*
 * System power and watchdog control: sleep state tracking, power control
 * sources, host watchdog with boot-progress use, and the controller
 * self-watchdog retry limiter.
 * Assumes inputs synchronous to i_clk and debounced one-cycle button pulses.
 */
`timescale 1ns/1ps
module spwc_top #(
	parameter longint QUIET_CYC = spwc_pkg::QUIET_CYC,
	parameter int BLINK_HALF_CYC = spwc_pkg::BLINK_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	input wire logic i_power_button,
	input wire logic i_reset_button,
	input wire logic i_nmi_button,
	input wire logic i_identify_button,
	input wire logic i_button_lock,
	input wire logic i_sleep_s1_enter,
	input wire logic i_sleep_s1_exit,
	input wire logic i_sleep_s3_enter,
	input wire logic i_chipset_power_on,
	input wire logic i_mains_restored,
	input wire logic i_self_wdt_reset,
	input wire logic i_self_reset_done,
	input wire logic i_system_reset,
	output logic o_power_on,
	output logic o_sys_reset,
	output logic o_nmi,
	output logic o_identify_toggle,
	output logic o_power_led,
	output logic o_status_degraded,
	output logic o_fans_run,
	output logic o_stay_loader,
	output logic o_log_self_reset
);
	typedef struct packed {
		spwc_pkg::spwc_sleep_t sleep;
		logic power;
		logic chip_prev;
		logic [31:0] ctrl;
		logic [31:0] wdt_load;
		logic [31:0] wdt_count;
		logic [2:0] events;
		logic [31:0] rdata;
		logic [31:0] blink_cnt;
		logic led;
		logic [7:0] cycle_cnt;
		logic [7:0] rst_cnt;
		logic [1:0] self_cnt;
		logic [63:0] quiet_cnt;
		logic log_pending;
		logic log_pulse;
		logic degraded;
		logic nmi;
		logic ident;
	} spwc_state_t;

	spwc_state_t cur;
	spwc_state_t next_st;

	function automatic logic btn_ok(input spwc_pkg::spwc_sleep_t s, input logic lock);
		// Lockout applies only in S0
		btn_ok = (s != spwc_pkg::SPWC_S0) || !lock;
	endfunction

	function automatic spwc_pkg::spwc_pwr_t wdt_req(input logic [1:0] act);
		// Expiry never maps to power-on
		wdt_req = (act == spwc_pkg::WDT_ACT_CYCLE) ? spwc_pkg::SPWC_PWR_CYCLE
			: spwc_pkg::SPWC_PWR_OFF;
	endfunction

	logic wdt_expire;
	logic boot_use;
	logic [1:0] wdt_act;
	logic cmd_wr;
	logic wdt_load_wr;

	always_comb
	begin
		next_st = cur;
		next_st.log_pulse = 1'b0;
		next_st.nmi = 1'b0;
		next_st.ident = 1'b0;
		boot_use = (cur.ctrl[spwc_pkg::CTRL_WDT_USE_LSB +: 3] == spwc_pkg::WDT_USE_BOOT_PROGRESS);
		wdt_act = cur.ctrl[spwc_pkg::CTRL_WDT_ACT_LSB +: 2];
		cmd_wr = i_wr && (i_addr == spwc_pkg::REG_CMD);
		wdt_load_wr = i_wr && (i_addr == spwc_pkg::REG_WDT_LOAD);
		wdt_expire = 1'b0;

		// Register writes
		if (i_wr)
		begin
			case (i_addr)
				spwc_pkg::REG_CTRL: next_st.ctrl = i_wdata;
				spwc_pkg::REG_WDT_LOAD:
				begin
					next_st.wdt_load = i_wdata;
					next_st.wdt_count = i_wdata;
				end
				spwc_pkg::REG_EVENT: next_st.events = cur.events & ~i_wdata[2:0];
				default: ;
			endcase
		end

		// Host watchdog, halted in S1; a reload wins over the tick
		if (cur.ctrl[spwc_pkg::CTRL_WDT_EN_BIT] && cur.power && cur.sleep != spwc_pkg::SPWC_S1
			&& cur.wdt_count != 32'h0000_0000 && !wdt_load_wr)
		begin
			next_st.wdt_count = cur.wdt_count - 32'h0000_0001;
			wdt_expire = (cur.wdt_count == 32'h0000_0001);
		end

		// Sleep states; S1 left only by host notification or by power off
		if (cur.power)
		begin
			if (cur.sleep == spwc_pkg::SPWC_S0 && i_sleep_s1_enter)
				next_st.sleep = spwc_pkg::SPWC_S1;
			else if (cur.sleep == spwc_pkg::SPWC_S0 && i_sleep_s3_enter
				&& cur.ctrl[spwc_pkg::CTRL_WORKSTATION_BIT])
				next_st.sleep = spwc_pkg::SPWC_S3;
			else if (cur.sleep != spwc_pkg::SPWC_S0 && i_sleep_s1_exit)
				next_st.sleep = spwc_pkg::SPWC_S0;
		end

		// Power control sources
		if (cur.cycle_cnt != 8'h00)
		begin
			next_st.cycle_cnt = cur.cycle_cnt - 8'h01;
			if (cur.cycle_cnt == 8'h01)
				next_st.power = 1'b1;
		end
		else if (wdt_expire && boot_use)
		begin
			next_st.rst_cnt = 8'(spwc_pkg::SYS_RESET_CYC);
		end
		else if (wdt_expire && wdt_act != spwc_pkg::WDT_ACT_NONE)
		begin
			if (wdt_act == spwc_pkg::WDT_ACT_HARD_RESET)
				next_st.rst_cnt = 8'(spwc_pkg::SYS_RESET_CYC);
			else if (wdt_req(wdt_act) == spwc_pkg::SPWC_PWR_CYCLE)
			begin
				next_st.power = 1'b0;
				next_st.cycle_cnt = 8'(spwc_pkg::CYCLE_OFF_CYC);
			end
			else
				next_st.power = 1'b0;
		end
		else if (cmd_wr && i_wdata[1:0] == spwc_pkg::CMD_ON)
			next_st.power = 1'b1;
		else if (cmd_wr && i_wdata[1:0] == spwc_pkg::CMD_OFF)
			next_st.power = 1'b0;
		else if (cmd_wr && i_wdata[1:0] == spwc_pkg::CMD_CYCLE)
		begin
			next_st.power = 1'b0;
			next_st.cycle_cnt = 8'(spwc_pkg::CYCLE_OFF_CYC);
		end
		else if (i_power_button && btn_ok(cur.sleep, i_button_lock))
			next_st.power = !cur.power;
		else if (i_chipset_power_on != cur.chip_prev)
			next_st.power = i_chipset_power_on;
		else if (i_mains_restored && cur.ctrl[spwc_pkg::CTRL_RETAIN_BIT])
			next_st.power = 1'b1;
		next_st.chip_prev = i_chipset_power_on;

		if (!next_st.power)
		begin
			next_st.sleep = spwc_pkg::SPWC_S5;
			next_st.wdt_count = 32'h0000_0000;
		end
		else if (!cur.power)
			next_st.sleep = spwc_pkg::SPWC_S0;

		// Expiry flags for next boot; no LED effect
		if (wdt_expire)
		begin
			next_st.events[spwc_pkg::EV_WDT_EXPIRED_BIT] = 1'b1;
			if (boot_use && cur.ctrl[spwc_pkg::CTRL_WDT_LOG_BIT])
				next_st.events[spwc_pkg::EV_BOOT_TIMEOUT_BIT] = 1'b1;
		end

		// Other buttons
		if (i_reset_button && cur.power && btn_ok(cur.sleep, i_button_lock))
			next_st.rst_cnt = 8'(spwc_pkg::SYS_RESET_CYC);
		if (i_nmi_button && cur.power && btn_ok(cur.sleep, i_button_lock))
			next_st.nmi = 1'b1;
		if (i_identify_button && btn_ok(cur.sleep, i_button_lock))
			next_st.ident = 1'b1;
		if (cur.rst_cnt != 8'h00 && next_st.rst_cnt == cur.rst_cnt)
			next_st.rst_cnt = cur.rst_cnt - 8'h01;

		// Power LED: steady in S0, 1 Hz blink in S1
		if (cur.sleep == spwc_pkg::SPWC_S1)
		begin
			if (cur.blink_cnt >= 32'(BLINK_HALF_CYC - 1))
			begin
				next_st.blink_cnt = 32'h0000_0000;
				next_st.led = !cur.led;
			end
			else
				next_st.blink_cnt = cur.blink_cnt + 32'h0000_0001;
		end
		else
		begin
			next_st.blink_cnt = 32'h0000_0000;
			next_st.led = cur.power && cur.sleep == spwc_pkg::SPWC_S0;
		end

		// Controller self-watchdog limiter
		if (i_self_wdt_reset)
		begin
			next_st.quiet_cnt = 64'h0;
			if (cur.self_cnt != 2'(spwc_pkg::SELF_RESET_MAX))
				next_st.self_cnt = cur.self_cnt + 2'h1;
			next_st.log_pending = 1'b1;
			next_st.degraded = 1'b1;
		end
		else if (cur.quiet_cnt > 64'(QUIET_CYC))
		begin
			next_st.self_cnt = 2'h0;
			next_st.quiet_cnt = 64'h0;
		end
		else
			next_st.quiet_cnt = cur.quiet_cnt + 64'h1;
		if (cur.log_pending && i_self_reset_done && !i_self_wdt_reset)
		begin
			next_st.log_pending = 1'b0;
			next_st.log_pulse = 1'b1;
			next_st.events[spwc_pkg::EV_SELF_RESET_BIT] = 1'b1;
		end
		if ((i_system_reset || (cur.power && !next_st.power)) && !i_self_wdt_reset)
			next_st.degraded = 1'b0;

		// Read data, valid the cycle after the strobe
		next_st.rdata = 32'h0000_0000;
		if (i_rd)
		begin
			case (i_addr)
				spwc_pkg::REG_CTRL: next_st.rdata = cur.ctrl;
				spwc_pkg::REG_STATUS: next_st.rdata = {24'h0, cur.degraded, cur.self_cnt,
					cur.power, cur.sleep, 2'h0};
				spwc_pkg::REG_WDT_LOAD: next_st.rdata = cur.wdt_load;
				spwc_pkg::REG_WDT_COUNT: next_st.rdata = cur.wdt_count;
				spwc_pkg::REG_EVENT: next_st.rdata = {29'h0, cur.events};
				default: next_st.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cur <= '0;
			cur.sleep <= spwc_pkg::SPWC_S5;
			cur.ctrl <= spwc_pkg::CTRL_RESET;
		end
		else
			cur <= next_st;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rdata <= 32'h0000_0000;
			o_power_on <= 1'b0;
			o_sys_reset <= 1'b0;
			o_nmi <= 1'b0;
			o_identify_toggle <= 1'b0;
			o_power_led <= 1'b0;
			o_status_degraded <= 1'b0;
			o_fans_run <= 1'b0;
			o_stay_loader <= 1'b0;
			o_log_self_reset <= 1'b0;
		end
		else
		begin
			o_rdata <= next_st.rdata;
			o_power_on <= next_st.power;
			o_sys_reset <= next_st.rst_cnt != 8'h00;
			o_nmi <= next_st.nmi;
			o_identify_toggle <= next_st.ident;
			o_power_led <= next_st.led;
			o_status_degraded <= next_st.degraded;
			o_fans_run <= next_st.power && next_st.sleep == spwc_pkg::SPWC_S0;
			o_stay_loader <= next_st.self_cnt == 2'(spwc_pkg::SELF_RESET_MAX);
			o_log_self_reset <= next_st.log_pulse;
		end
	end
endmodule

// File: verif/spwc_chk.sv
/* Port assertions for the power and watchdog control block.
   Bound to spwc_top from the bench top file. */
`timescale 1ns/1ps
module spwc_chk #(
	parameter longint QUIET_CYC = 200,
	parameter int BLINK_HALF_CYC = 8
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_power_button,
	input wire logic i_nmi_button,
	input wire logic i_identify_button,
	input wire logic i_button_lock,
	input wire logic i_system_reset,
	input wire logic o_power_on,
	input wire logic o_sys_reset,
	input wire logic o_nmi,
	input wire logic o_identify_toggle,
	input wire logic o_status_degraded,
	input wire logic o_fans_run,
	input wire logic o_log_self_reset
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	property p_fans;
		o_fans_run |-> o_power_on;
	endproperty
	a_fans: assert property (p_fans) else $error("fans run unpowered");
	property p_cmd;
		i_wr && i_addr == spwc_pkg::REG_CMD && i_wdata[1:0] == spwc_pkg::CMD_OFF |=> !o_power_on;
	endproperty
	a_cmd: assert property (p_cmd) else $error("off command ignored");
	property p_btn;
		i_power_button && !i_button_lock && !i_wr |=> o_power_on != $past(o_power_on);
	endproperty
	a_btn: assert property (p_btn) else $error("power button did not toggle");
	property p_nmi;
		o_nmi |-> $past(i_nmi_button);
	endproperty
	a_nmi: assert property (p_nmi) else $error("nmi without press");
	property p_id;
		i_identify_button && !i_button_lock |=> o_identify_toggle;
	endproperty
	a_id: assert property (p_id) else $error("identify press lost");
	property p_sysrst;
		$rose(o_sys_reset) |=> o_sys_reset [*8];
	endproperty
	a_sysrst: assert property (p_sysrst) else $error("system reset too short");
	property p_log;
		o_log_self_reset |=> !o_log_self_reset;
	endproperty
	a_log: assert property (p_log) else $error("log pulse too long");
	property p_degr;
		$fell(o_status_degraded) |-> $past(i_system_reset) || !o_power_on;
	endproperty
	a_degr: assert property (p_degr) else $error("degraded cleared early");
endmodule

// File: verif/spwc_host_model.sv
/* Host and front panel model: button presses and sleep notices.
   Caller invokes pulse just after a rising clock edge. */
`timescale 1ns/1ps
module spwc_host_model (
	input wire logic i_clk,
	output logic o_power_button,
	output logic o_reset_button,
	output logic o_nmi_button,
	output logic o_identify_button,
	output logic o_s1_enter,
	output logic o_s1_exit,
	output logic o_s3_enter
);
	initial {o_s3_enter, o_s1_exit, o_s1_enter, o_identify_button, o_nmi_button, o_reset_button, o_power_button} = 7'h00;
	// One-cycle pulse; index 5 is the exit notice from the host handler
	task pulse(input int k);
		{o_s3_enter, o_s1_exit, o_s1_enter, o_identify_button, o_nmi_button, o_reset_button, o_power_button} <= 7'h01 << k;
		@(posedge i_clk);
		{o_s3_enter, o_s1_exit, o_s1_enter, o_identify_button, o_nmi_button, o_reset_button, o_power_button} <= 7'h00;
	endtask
endmodule

// File: verif/spwc_tb_top.sv
/* Self-checking bench for spwc_top with the host model.
   Shortened blink and quiet periods. */
`timescale 1ns/1ps
module spwc_tb_top;
	localparam int BH = 8;
	typedef struct {logic [1:0] c; logic [31:0] e;} spwc_row_t;
	spwc_row_t rows[4] = '{'{spwc_pkg::CMD_ON, 32'h1}, '{spwc_pkg::CMD_OFF, 32'h0},
		'{spwc_pkg::CMD_ON, 32'h1}, '{spwc_pkg::CMD_CYCLE, 32'h0}};
	logic i_clk = 0, i_rst_n = 0, i_wr = 0, i_rd = 0, i_button_lock = 0, i_chipset_power_on = 0;
	logic i_mains_restored = 0, i_self_wdt_reset = 0, i_self_reset_done = 0, i_system_reset = 0, l;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic i_power_button, i_reset_button, i_nmi_button, i_identify_button;
	logic i_sleep_s1_enter, i_sleep_s1_exit, i_sleep_s3_enter;
	logic o_power_on, o_sys_reset, o_nmi, o_identify_toggle, o_power_led;
	logic o_status_degraded, o_fans_run, o_stay_loader, o_log_self_reset;
	int miscompares = 0, tests_run = 0;
	always #4 i_clk = ~i_clk;
	spwc_top #(.QUIET_CYC(200), .BLINK_HALF_CYC(BH)) spwc_top_i (.*);
	spwc_host_model spwc_host_model_i (.i_clk(i_clk), .o_power_button(i_power_button),
		.o_reset_button(i_reset_button), .o_nmi_button(i_nmi_button), .o_identify_button(i_identify_button),
		.o_s1_enter(i_sleep_s1_enter), .o_s1_exit(i_sleep_s1_exit), .o_s3_enter(i_sleep_s3_enter));
	task results;
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			miscompares++;
			$display("wrong value t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task tk(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task rd(input logic [7:0] a);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask
	task pr(input int k);
		spwc_host_model_i.pulse(k);
		#1;
	endtask
	// Bounded wait: 0 system reset, 1 log pulse, 2 power off
	task wt(input int s);
		int n;
		n = 0;
		while (n < 999 && (s == 0 ? o_sys_reset : s == 1 ? o_log_self_reset : !o_power_on) !== 1'b1)
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		if (n == 999)
		begin
			miscompares++;
			results();
		end
	endtask
	initial
	begin
		repeat (20) @(posedge i_clk);
		i_rst_n <= 1'b1;
		#1;
		chk(o_fans_run, 32'h0);
		rd(spwc_pkg::REG_STATUS);
		chk(d[3:2], 32'h3);
		rd(8'hFC);
		chk(d, 32'h0);
		i_button_lock <= 1'b1;
		pr(3);
		chk(o_identify_toggle, 32'h1);
		foreach (rows[i])
		begin
			wr(spwc_pkg::REG_CMD, {30'h0, rows[i].c});
			chk(o_power_on, rows[i].e);
		end
		tk(130);
		chk(o_power_on, 32'h1);
		chk(o_fans_run, 32'h1);
		pr(3);
		chk(o_identify_toggle, 32'h0);
		pr(4);
		rd(spwc_pkg::REG_STATUS);
		chk(d[3:2], 32'h1);
		l = o_power_led;
		tk(BH);
		chk(o_power_led, !l);
		tk(BH);
		chk(o_power_led, l);
		pr(2);
		chk(o_nmi, 32'h1);
		pr(3);
		chk(o_identify_toggle, 32'h1);
		i_button_lock <= 1'b0;
		wr(spwc_pkg::REG_CTRL, 32'h2);
		wr(spwc_pkg::REG_WDT_LOAD, 32'h28);
		tk(10);
		rd(spwc_pkg::REG_WDT_COUNT);
		chk(d, 32'h28);
		pr(5);
		rd(spwc_pkg::REG_STATUS);
		chk(d[3:2], 32'h0);
		pr(6);
		rd(spwc_pkg::REG_STATUS);
		chk(d[3:2], 32'h0);
		wr(spwc_pkg::REG_CTRL, 32'h116);
		wr(spwc_pkg::REG_WDT_LOAD, 32'h14);
		l = o_power_led;
		wt(0);
		chk(o_power_led, l);
		chk(o_power_on, 32'h1);
		rd(spwc_pkg::REG_EVENT);
		chk(d & 32'h2, 32'h2);
		wr(spwc_pkg::REG_CTRL, 32'h0);
		wr(spwc_pkg::REG_EVENT, 32'h7);
		repeat (3)
		begin
			i_self_wdt_reset <= 1'b1;
			tk(1);
			i_self_wdt_reset <= 1'b0;
			chk(o_log_self_reset, 32'h0);
			i_self_reset_done <= 1'b1;
			tk(1);
			i_self_reset_done <= 1'b0;
			wt(1);
		end
		chk(o_status_degraded, 32'h1);
		chk(o_stay_loader, 32'h1);
		tk(210);
		chk(o_stay_loader, 32'h0);
		repeat (2)
		begin
			i_self_wdt_reset <= 1'b1;
			tk(1);
			i_self_wdt_reset <= 1'b0;
			tk(150);
		end
		rd(spwc_pkg::REG_STATUS);
		chk(d[6:5], 32'h2);
		i_system_reset <= 1'b1;
		tk(1);
		i_system_reset <= 1'b0;
		chk(o_status_degraded, 32'h0);
		pr(0);
		chk(o_power_on, 32'h0);
		pr(0);
		chk(o_power_on, 32'h1);
		i_chipset_power_on <= 1'b1;
		tk(2);
		i_chipset_power_on <= 1'b0;
		tk(1);
		chk(o_power_on, 32'h0);
		wr(spwc_pkg::REG_CTRL, 32'h1);
		i_mains_restored <= 1'b1;
		tk(1);
		i_mains_restored <= 1'b0;
		chk(o_power_on, 32'h1);
		wr(spwc_pkg::REG_CTRL, 32'h202);
		wr(spwc_pkg::REG_WDT_LOAD, 32'hA);
		wt(2);
		chk(o_power_on, 32'h0);
		wr(spwc_pkg::REG_CMD, 32'h1);
		wr(spwc_pkg::REG_CTRL, 32'h302);
		wr(spwc_pkg::REG_WDT_LOAD, 32'hA);
		wt(2);
		chk(o_power_on, 32'h0);
		tk(124);
		chk(o_power_on, 32'h0);
		tk(1);
		chk(o_power_on, 32'h1);
		wr(spwc_pkg::REG_CTRL, 32'h102);
		wr(spwc_pkg::REG_WDT_LOAD, 32'hA);
		wt(0);
		chk(o_power_on, 32'h1);
		tk(15);
		chk(o_sys_reset, 32'h1);
		tk(1);
		chk(o_sys_reset, 32'h0);
		wr(spwc_pkg::REG_CTRL, 32'h0);
		i_button_lock <= 1'b1;
		pr(1);
		chk(o_sys_reset, 32'h0);
		pr(2);
		chk(o_nmi, 32'h0);
		i_button_lock <= 1'b0;
		pr(1);
		chk(o_sys_reset, 32'h1);
		results();
	end
endmodule
bind spwc_top spwc_chk #(.QUIET_CYC(QUIET_CYC), .BLINK_HALF_CYC(BLINK_HALF_CYC)) spwc_chk_i (.*);
